// File: rtl/ocu_output_compare.sv
/*
 * five-channel output compare unit: compare registers, flag and mask
 * registers, pin action control and channel-one multi-pin action.
 * assumes a byte-wide register port on the same clock, and the free
 * running counter supplied by the timer core on the same clock.
 */
// Design decision made here: strobed register access.
`timescale 1ns/100ps
module ocu_output_compare
   import ocu_pkg::*;
#(
   parameter int NUM_CH = OCU_NUM_CH,
   parameter int CNT_W  = OCU_CNT_W
)(
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_sys_rst,
   input  wire logic [OCU_ADDR_W-1:0] i_addr,
   input  wire logic [OCU_DATA_W-1:0] i_wdata,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   input  wire logic [CNT_W-1:0]      i_free_running_counter,
   output logic [OCU_DATA_W-1:0]      o_rdata,
   output logic                       o_irq,
   output logic [NUM_CH-1:0]          o_port_level,
   output logic [NUM_CH-1:0]          o_port_timer_drive,
   output logic [NUM_CH-1:0]          o_compare_match
);

   // ************************************************************
   // helpers
   // ************************************************************

   // channel i (0 is channel one) owns flag, mask and port index 4-i
   function automatic int ocu_slot(input int ch);
      ocu_slot = NUM_CH - 1 - ch;
   endfunction

   function automatic logic [15:0] ocu_cmp_addr(input int ch, input logic lo);
      ocu_cmp_addr = OCU_ADDR_CMP1_HI + 16'(2 * ch) + {15'h0000, lo};
   endfunction

   // implemented bits seven to three of a flag, mask or pin field byte
   function automatic logic [NUM_CH-1:0] ocu_field(input logic [OCU_DATA_W-1:0] d);
      ocu_field = d[OCU_DATA_W-1:OCU_FIELD_LSB];
   endfunction

   // ************************************************************
   // state
   // ************************************************************
   logic [CNT_W-1:0]      cmp_q [NUM_CH];
   logic [NUM_CH-1:0]     inhibit_q;
   logic [NUM_CH-1:0]     pin_mask_q;
   logic [NUM_CH-1:0]     pin_data_q;
   logic [7:0]            ctrl1_q;
   logic [NUM_CH-1:0]     irq_mask_q;
   logic [NUM_CH-1:0]     flag_q;
   logic [NUM_CH-1:0]     flag_d;
   logic                  sel_capture_q;
   logic [OCU_DATA_W-1:0] rdata_d;
   logic [OCU_DATA_W-1:0] rdata_q;
   logic [NUM_CH-1:0]     match;
   logic [NUM_CH-1:0]     match_slot;
   logic [NUM_CH-1:0]     ch_enable;
   logic [NUM_CH-1:0]     hi_wr;
   logic [NUM_CH-1:0]     lo_wr;
   logic                  wr_pin_mask;
   logic                  wr_pin_data;
   logic                  wr_ctrl1;
   logic                  wr_irq_mask;
   logic                  wr_flag;
   logic                  wr_select;
   ocu_action_t           action [NUM_CH];

   // ************************************************************
   // address decode
   // ************************************************************
   always_comb
   begin
      for (int i = 0; i < NUM_CH; i++)
      begin
         hi_wr[i] = i_wr && (i_addr == ocu_cmp_addr(i, 1'b0));
         lo_wr[i] = i_wr && (i_addr == ocu_cmp_addr(i, 1'b1));
      end
      // writes to the shared register are ignored while it captures
      hi_wr[NUM_CH-1] = hi_wr[NUM_CH-1] & ~sel_capture_q;
      lo_wr[NUM_CH-1] = lo_wr[NUM_CH-1] & ~sel_capture_q;
   end

   // one write strobe for each single-byte register
   assign wr_pin_mask = i_wr && (i_addr == OCU_ADDR_PIN_MASK);
   assign wr_pin_data = i_wr && (i_addr == OCU_ADDR_PIN_DATA);
   assign wr_ctrl1    = i_wr && (i_addr == OCU_ADDR_CTRL1);
   assign wr_irq_mask = i_wr && (i_addr == OCU_ADDR_MASK1);
   assign wr_flag     = i_wr && (i_addr == OCU_ADDR_FLAG1);
   assign wr_select   = i_wr && (i_addr == OCU_ADDR_PULSE_ACCUMULATOR_CONTROL);

   // ************************************************************
   // compare registers
   // ************************************************************
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         for (int i = 0; i < NUM_CH; i++)
            cmp_q[i] <= OCU_CMP_RESET;
      end
      else
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            if (hi_wr[i])
               cmp_q[i][CNT_W-1:8] <= i_wdata;
            if (lo_wr[i])
               cmp_q[i][7:0] <= i_wdata;
         end
      end
   end

   // the cycle after a high byte write holds a half-new value
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         inhibit_q <= '0;
      else
         inhibit_q <= hi_wr;
   end

   // ************************************************************
   // control registers
   // ************************************************************
   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         pin_mask_q <= OCU_FIELD_RESET;
         pin_data_q <= OCU_FIELD_RESET;
      end
      else
      begin
         if (wr_pin_mask)
            pin_mask_q <= ocu_field(i_wdata);
         if (wr_pin_data)
            pin_data_q <= ocu_field(i_wdata);
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         ctrl1_q <= OCU_CTRL_RESET;
      else if (wr_ctrl1)
         ctrl1_q <= i_wdata;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         irq_mask_q <= OCU_FIELD_RESET;
      else if (wr_irq_mask)
         irq_mask_q <= ocu_field(i_wdata);
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         sel_capture_q <= OCU_SEL_RESET;
      else if (wr_select)
         sel_capture_q <= i_wdata[OCU_SEL_BIT];
   end

   // ************************************************************
   // comparators
   // ************************************************************
   always_comb
   begin
      ch_enable = '1;
      ch_enable[NUM_CH-1] = ~sel_capture_q;
   end

   for (genvar g = 0; g < NUM_CH; g++)
   begin : g_cmp
      ocu_compare_channel #(
         .CNT_W (CNT_W)
      ) u_cmp (
         .i_sys_clk (i_sys_clk),
         .i_sys_rst (i_sys_rst),
         .i_compare (cmp_q[g]),
         .i_counter (i_free_running_counter),
         .i_inhibit (inhibit_q[g]),
         .i_enable  (ch_enable[g]),
         .o_match   (match[g])
      );
   end

   always_comb
   begin
      for (int i = 0; i < NUM_CH; i++)
         match_slot[ocu_slot(i)] = match[i];
   end

   // ************************************************************
   // flags and interrupt
   // ************************************************************
   always_comb
   begin
      flag_d = flag_q;
      if (wr_flag)
         flag_d = flag_d & ~ocu_field(i_wdata);
      // a match in the clearing cycle still sets the flag
      flag_d = flag_d | match_slot;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         flag_q <= OCU_FIELD_RESET;
      else
         flag_q <= flag_d;
   end

   assign o_irq = |(flag_q & irq_mask_q);

   // ************************************************************
   // pin actions
   // ************************************************************
   always_comb
   begin
      action[0] = OCU_ACT_OFF;
      for (int i = 1; i < NUM_CH; i++)
         action[i] = ocu_action_t'(ctrl1_q[9-2*i -: 2]);
      if (sel_capture_q)
         action[NUM_CH-1] = OCU_ACT_OFF;
   end

   for (genvar g = 0; g < NUM_CH; g++)
   begin : g_pin
      // action runs on every match regardless of the flag state
      ocu_pin_drive u_pin (
         .i_sys_clk     (i_sys_clk),
         .i_sys_rst     (i_sys_rst),
         .i_own_match   (match[g]),
         .i_action      (action[g]),
         .i_ch1_match   (match[0]),
         .i_ch1_mask    (pin_mask_q[ocu_slot(g)]),
         .i_ch1_data    (pin_data_q[ocu_slot(g)]),
         .o_level       (o_port_level[ocu_slot(g)]),
         .o_timer_drive (o_port_timer_drive[ocu_slot(g)])
      );
   end

   assign o_compare_match = match;

   // ************************************************************
   // read path
   // ************************************************************
   always_comb
   begin
      rdata_d = 8'h00;
      for (int i = 0; i < NUM_CH; i++)
      begin
         if (i_addr == ocu_cmp_addr(i, 1'b0))
            rdata_d = cmp_q[i][CNT_W-1:8];
         if (i_addr == ocu_cmp_addr(i, 1'b1))
            rdata_d = cmp_q[i][7:0];
      end
      unique case (i_addr)
         OCU_ADDR_PIN_MASK: rdata_d = {pin_mask_q, 3'h0};
         OCU_ADDR_PIN_DATA: rdata_d = {pin_data_q, 3'h0};
         OCU_ADDR_CTRL1:    rdata_d = ctrl1_q;
         OCU_ADDR_MASK1:    rdata_d = {irq_mask_q, 3'h0};
         OCU_ADDR_FLAG1:    rdata_d = {flag_q, 3'h0};
         OCU_ADDR_PULSE_ACCUMULATOR_CONTROL:    rdata_d = 8'(sel_capture_q) << OCU_SEL_BIT;
         default:           rdata_d = rdata_d;
      endcase
      if (!i_rd)
         rdata_d = 8'h00;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         rdata_q <= 8'h00;
      else
         rdata_q <= rdata_d;
   end

   assign o_rdata = rdata_q;

endmodule

// File: rtl/ocu_pkg.sv
/*
 * constants for the five-channel output compare unit: register byte
 * addresses, field positions, reset values and the pin action encoding.
 * assumes a byte-wide register port with 16-bit byte addresses.
 */
package ocu_pkg;

   // ************************************************************
   // widths
   // ************************************************************
   localparam int OCU_ADDR_W = 16;
   localparam int OCU_DATA_W = 8;
   localparam int OCU_CNT_W  = 16;
   localparam int OCU_NUM_CH = 5;

   // ************************************************************
   // register byte addresses
   // ************************************************************
   localparam logic [15:0] OCU_ADDR_PIN_MASK = 16'h100c;
   localparam logic [15:0] OCU_ADDR_PIN_DATA = 16'h100d;
   localparam logic [15:0] OCU_ADDR_CMP1_HI  = 16'h1016;
   localparam logic [15:0] OCU_ADDR_CMP2_HI  = 16'h1018;
   localparam logic [15:0] OCU_ADDR_CMP3_HI  = 16'h101a;
   localparam logic [15:0] OCU_ADDR_CMP4_HI  = 16'h101c;
   localparam logic [15:0] OCU_ADDR_CMP5_HI  = 16'h101e;
   localparam logic [15:0] OCU_ADDR_CTRL1    = 16'h1020;
   localparam logic [15:0] OCU_ADDR_MASK1    = 16'h1022;
   localparam logic [15:0] OCU_ADDR_FLAG1    = 16'h1023;
   localparam logic [15:0] OCU_ADDR_PULSE_ACCUMULATOR_CONTROL    = 16'h1026;

   // ************************************************************
   // fields and reset values
   // ************************************************************
   localparam int          OCU_FIELD_LSB   = 3;
   localparam int          OCU_SEL_BIT     = 2;
   localparam logic [15:0] OCU_CMP_RESET   = 16'hffff;
   localparam logic [4:0]  OCU_FIELD_RESET = 5'h00;
   localparam logic [7:0]  OCU_CTRL_RESET  = 8'h00;
   localparam logic        OCU_SEL_RESET   = 1'b0;

   // ************************************************************
   // pin action on a match
   // ************************************************************
   typedef enum logic [1:0] {
      OCU_ACT_OFF    = 2'b00,
      OCU_ACT_TOGGLE = 2'b01,
      OCU_ACT_CLEAR  = 2'b10,
      OCU_ACT_SET    = 2'b11
   } ocu_action_t;

endpackage

// File: rtl/ocu_compare_channel.sv
/*
 * one equality comparator of the output compare unit.
 * assumes the counter comes from logic on the same clock.
 */
`timescale 1ns/100ps
module ocu_compare_channel
   import ocu_pkg::*;
#(
   parameter int CNT_W = OCU_CNT_W
)(
   input  wire logic             i_sys_clk,
   input  wire logic             i_sys_rst,
   input  wire logic [CNT_W-1:0] i_compare,
   input  wire logic [CNT_W-1:0] i_counter,
   input  wire logic             i_inhibit,
   input  wire logic             i_enable,
   output logic                  o_match
);

   logic equal;
   logic equal_q;

   // compared every clock; a held counter value matches only once
   assign equal = (i_compare == i_counter);

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         equal_q <= 1'b0;
      else
         equal_q <= equal;
   end

   assign o_match = equal & ~equal_q & ~i_inhibit & i_enable;

endmodule

// File: rtl/ocu_pin_drive.sv
/*
 * level of one compare output pin, moved by its own channel and by
 * channel one through the pin mask and pin data bits.
 * assumes match inputs are one-cycle pulses on the same clock.
 */
`timescale 1ns/100ps
module ocu_pin_drive
   import ocu_pkg::*;
(
   input  wire logic        i_sys_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_own_match,
   input  ocu_action_t      i_action,
   input  wire logic        i_ch1_match,
   input  wire logic        i_ch1_mask,
   input  wire logic        i_ch1_data,
   output logic             o_level,
   output logic             o_timer_drive
);

   logic level_q;
   logic level_d;

   always_comb
   begin
      level_d = level_q;
      if (i_own_match)
      begin
         unique case (i_action)
            OCU_ACT_OFF:    level_d = level_q;
            OCU_ACT_TOGGLE: level_d = ~level_q;
            OCU_ACT_CLEAR:  level_d = 1'b0;
            OCU_ACT_SET:    level_d = 1'b1;
         endcase
      end
      // channel one is applied last, so it wins a same-cycle clash
      if (i_ch1_match && i_ch1_mask)
         level_d = i_ch1_data;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
         level_q <= 1'b0;
      else
         level_q <= level_d;
   end

   assign o_level       = level_q;
   assign o_timer_drive = (i_action != OCU_ACT_OFF) | i_ch1_mask;

endmodule

// File: dv/ocu_pin_load.sv
/*
 * loads on the five compare output pins: a driven pin follows the unit,
 * an undriven one floats and shows a level that keeps changing.
 * assumes pin bits in the unit's own order and the unit's clock.
 */
`timescale 1ns/100ps
module ocu_pin_load
(
   input  wire logic       i_sys_clk,
   input  wire logic [4:0] i_level,
   input  wire logic [4:0] i_timer_drive,
   output logic [4:0]      o_pin
);
   logic [4:0] last_q = 5'h00;
   // a disconnected pin must never look as if it held its last value
   assign o_pin = (i_timer_drive & i_level) | (~i_timer_drive & ~last_q);
   always_ff @(posedge i_sys_clk)
   begin
      last_q <= o_pin;
   end
endmodule

// File: dv/ocu_output_compare_assertions.sv
/*
 * port checker of the output compare unit, bound to its top module.
 * assumes one clock and the synchronous active-high reset.
 */
`timescale 1ns/100ps
module ocu_checker
   import ocu_pkg::*;
#(
   parameter int NUM_CH = OCU_NUM_CH,
   parameter int CNT_W  = OCU_CNT_W
)(
   input wire logic                  i_sys_clk,
   input wire logic                  i_sys_rst,
   input wire logic [OCU_ADDR_W-1:0] i_addr,
   input wire logic [OCU_DATA_W-1:0] i_wdata,
   input wire logic                  i_wr,
   input wire logic                  i_rd,
   input wire logic [CNT_W-1:0]      i_free_running_counter,
   input wire logic [OCU_DATA_W-1:0] o_rdata,
   input wire logic                  o_irq,
   input wire logic [NUM_CH-1:0]     o_port_level,
   input wire logic [NUM_CH-1:0]     o_port_timer_drive,
   input wire logic [NUM_CH-1:0]     o_compare_match
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   logic [NUM_CH-1:0] inh_q;
   // channels whose high byte was written at the last edge
   always_ff @(posedge i_sys_clk)
   begin
      for (int k = 0; k < NUM_CH; k++)
      begin
         inh_q[k] <= !i_sys_rst && i_wr && (i_addr == OCU_ADDR_CMP1_HI + 16'(2 * k));
      end
   end
   inhibit_write_a: assert property ((inh_q & o_compare_match) == '0)
      else $error("match in the cycle after a high byte write");
   match_pulse_a: assert property (!$past(i_sys_rst) |->
      (o_compare_match & $past(o_compare_match)) == '0) else $error("match held two cycles");
   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == '0)
      else $error("read data outside the read answer cycle");
   irq_rise_a: assert property ($rose(o_irq) && !$past(i_sys_rst) |->
      $past(i_wr) || $past(|o_compare_match)) else $error("interrupt rose without cause");
   irq_fall_a: assert property ($fell(o_irq) && !$past(i_sys_rst) |-> $past(i_wr))
      else $error("interrupt fell without a write");
   level_cause_a: assert property ($changed(o_port_level) && !$past(i_sys_rst) |->
      $past(|o_compare_match)) else $error("pin level moved without a match");
   level_drive_a: assert property (!$past(i_sys_rst) |->
      ((o_port_level ^ $past(o_port_level)) & ~$past(o_port_timer_drive)) == '0)
      else $error("disconnected pin level moved");
   drive_cause_a: assert property ($changed(o_port_timer_drive) && !$past(i_sys_rst) |->
      $past(i_wr)) else $error("pin drive changed without a write");
endmodule
bind ocu_output_compare ocu_checker #(.NUM_CH(NUM_CH), .CNT_W(CNT_W)) u_chk (
   .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
   .i_wr(i_wr), .i_rd(i_rd), .i_free_running_counter(i_free_running_counter),
   .o_rdata(o_rdata), .o_irq(o_irq), .o_port_level(o_port_level),
   .o_port_timer_drive(o_port_timer_drive), .o_compare_match(o_compare_match));

// File: dv/ocu_output_compare_tb_top.sv
/*
 * self-checking bench of the output compare unit: register access, pin
 * actions, channel-one pins, interrupt, compare inhibit, channel five.
 * assumes the package, the pin load model and the checker come first.
 */
`timescale 1ns/100ps
module ocu_output_compare_tb_top;
   import ocu_pkg::*;
   localparam logic [1:0]  CODES [5] = '{2'b11, 2'b01, 2'b10, 2'b01, 2'b00};
   localparam logic [15:0] ZADDR [7] = '{OCU_ADDR_PIN_MASK, OCU_ADDR_PIN_DATA, OCU_ADDR_CTRL1,
      OCU_ADDR_MASK1, OCU_ADDR_FLAG1, OCU_ADDR_PULSE_ACCUMULATOR_CONTROL, 16'h1030};
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic [7:0]  wdata = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [15:0] cnt = 16'h0000;
   logic [7:0]  rdata;
   logic        irq;
   logic [4:0]  lvl, drv, mat, pins;
   logic [4:0]  exp_lv = 5'h00;
   int          bad_count = 0;
   int          n_checks = 0;
   always #5 clk = ~clk;
   ocu_output_compare u_dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_free_running_counter(cnt),
      .o_rdata(rdata), .o_irq(irq), .o_port_level(lvl), .o_port_timer_drive(drv),
      .o_compare_match(mat));
   ocu_pin_load u_load (.i_sys_clk(clk), .i_level(lvl), .i_timer_drive(drv), .o_pin(pins));
   task automatic stop_test();
      if (bad_count == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
         bad_count++;
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      chk(rdata, e);
   endtask
   task automatic wr16(input logic [15:0] a, input logic [15:0] v);
      wr_reg(a, v[15:8]);
      wr_reg(a + 16'h0001, v[7:0]);
   endtask
   task automatic step(input logic [15:0] v);
      @(posedge clk);
      cnt <= v;
      #1;
   endtask
   // counter steps into equality with v: check the pulse, then let pins settle
   task automatic hit(input logic [15:0] v, input logic [4:0] em);
      step(v - 16'h0001);
      step(v);
      chk({3'h0, mat}, {3'h0, em});
      @(posedge clk);
      #1;
   endtask
   initial
   begin
      #500000;
      bad_count++;
      stop_test();
   end
   // ************************************************************
   // stimulus
   // ************************************************************
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      for (int a = 16'h1016; a <= 16'h101f; a++)
         rd_chk(16'(a), 8'hff);
      for (int i = 0; i < 7; i++)
         rd_chk(ZADDR[i], 8'h00);
      for (int a = 16'h1016; a <= 16'h101f; a++)
         wr_reg(16'(a), 8'(a) ^ 8'h5a);
      for (int a = 16'h1016; a <= 16'h101f; a++)
         rd_chk(16'(a), 8'(a) ^ 8'h5a);
      for (int k = 0; k < 4; k++)
         wr16(OCU_ADDR_CMP2_HI + 16'(2 * k), 16'h1234);
      for (int i = 0; i < 5; i++)
      begin
         wr_reg(OCU_ADDR_CTRL1, {4{CODES[i]}});
         hit(16'h1234, 5'h1e);
         case (CODES[i])
            2'b11: exp_lv[3:0] = 4'hf;
            2'b10: exp_lv[3:0] = 4'h0;
            2'b01: exp_lv[3:0] = ~exp_lv[3:0];
            default: exp_lv[3:0] = exp_lv[3:0];
         endcase
         chk({3'h0, lvl}, {3'h0, exp_lv});
         chk({3'h0, drv}, (CODES[i] == 2'b00) ? 8'h00 : 8'h0f);
         chk({3'h0, pins & drv}, {3'h0, exp_lv & drv});
      end
      rd_chk(OCU_ADDR_FLAG1, 8'h78);
      chk({7'h0, irq}, 8'h00);
      wr_reg(OCU_ADDR_MASK1, 8'h40);
      chk({7'h0, irq}, 8'h01);
      wr_reg(OCU_ADDR_FLAG1, 8'h00);
      rd_chk(OCU_ADDR_FLAG1, 8'h78);
      wr_reg(OCU_ADDR_FLAG1, 8'h40);
      rd_chk(OCU_ADDR_FLAG1, 8'h38);
      chk({7'h0, irq}, 8'h00);
      wr_reg(OCU_ADDR_FLAG1, 8'hff);
      wr_reg(OCU_ADDR_PIN_MASK, 8'hff);
      rd_chk(OCU_ADDR_PIN_MASK, 8'hf8);
      wr_reg(OCU_ADDR_PIN_DATA, 8'hff);
      rd_chk(OCU_ADDR_PIN_DATA, 8'hf8);
      wr_reg(OCU_ADDR_CTRL1, 8'h00);
      wr_reg(OCU_ADDR_PIN_MASK, 8'ha8);
      wr_reg(OCU_ADDR_PIN_DATA, 8'h20);
      chk({3'h0, drv}, 8'h15);
      wr16(OCU_ADDR_CMP1_HI, 16'h2000);
      hit(16'h2000, 5'h01);
      exp_lv = {1'b0, exp_lv[3], 1'b1, exp_lv[1], 1'b0};
      chk({3'h0, lvl}, {3'h0, exp_lv});
      rd_chk(OCU_ADDR_FLAG1, 8'h80);
      wr_reg(OCU_ADDR_PIN_MASK, 8'h00);
      wr_reg(OCU_ADDR_CTRL1, 8'h40);
      wr_reg(OCU_ADDR_CMP2_HI + 16'h0001, 8'h00);
      @(posedge clk);
      addr  <= OCU_ADDR_CMP2_HI;
      wdata <= 8'h05;
      wr    <= 1'b1;
      cnt   <= 16'h0500;
      @(posedge clk);
      wr    <= 1'b0;
      #1;
      chk({3'h0, mat}, 8'h00);
      step(16'h0500);
      chk({3'h0, lvl}, {3'h0, exp_lv});
      hit(16'h0500, 5'h02);
      exp_lv[3] = ~exp_lv[3];
      chk({3'h0, lvl}, {3'h0, exp_lv});
      wr_reg(OCU_ADDR_PULSE_ACCUMULATOR_CONTROL, 8'hff);
      rd_chk(OCU_ADDR_PULSE_ACCUMULATOR_CONTROL, 8'h04);
      wr_reg(OCU_ADDR_CMP5_HI, 8'h77);
      rd_chk(OCU_ADDR_CMP5_HI, 8'h12);
      wr_reg(OCU_ADDR_CTRL1, 8'h03);
      hit(16'h1234, 5'h0c);
      chk({3'h0, lvl}, {3'h0, exp_lv});
      rd_chk(OCU_ADDR_FLAG1, 8'hf0);
      wr_reg(OCU_ADDR_PULSE_ACCUMULATOR_CONTROL, 8'h00);
      hit(16'h1234, 5'h1c);
      exp_lv[0] = 1'b1;
      chk({3'h0, lvl}, {3'h0, exp_lv});
      // pulse: leading edge at a set level, then old value plus width at clear
      wr_reg(OCU_ADDR_CTRL1, 8'hc0);
      wr16(OCU_ADDR_CMP2_HI, 16'h3000);
      hit(16'h3000, 5'h02);
      exp_lv[3] = 1'b1;
      chk({3'h0, lvl}, {3'h0, exp_lv});
      wr_reg(OCU_ADDR_CTRL1, 8'h80);
      wr16(OCU_ADDR_CMP2_HI, 16'h3000 + 16'h0040);
      hit(16'h3040, 5'h02);
      exp_lv[3] = 1'b0;
      chk({3'h0, lvl}, {3'h0, exp_lv});
      stop_test();
   end
endmodule
